// File: hdl/pmec_top.sv
`default_nettype none
// Notes on behaviour
// (R1) Select code picks time-base bit 63/55/51/47.
// (R2) Enabled time-base rising edge raises interrupt.
// (R3) Only software changes the edge enable.
// (R4) Six-bit threshold field is fully read/write.
// (R5) Counter one negative interrupts when enabled.
// (R6) Counter two enable overrides freeze on interrupt.
// (R7) Hold counter two until trigger or interrupt.
// (R8) Seven-bit event selector for counter one.
// (R9) Six-bit event selector for counter two.
// (R10) Count only in the configured state.
// (R11) Eight state conditions gate counting.
// (R12) Freeze bits all zero: always count.
// (R13) Freeze-always bit stops all counting.
// (R14) Two 32-bit counters, reset clear, loadable.
// (R15) Sign bit marks a counter negative.
// (R16) Interrupt clears the global enable bit.
// (R17) Freeze on interrupt stops the counters; counter two keeps counting while its trigger hold is set.
// (R18) Per-state freeze bits stop both counters.
// (R19) Edge found by keeping the previous sample.
// (R20) Interrupt only when enabled; clears enable.
// ----------------------------------------------------------------
// Top of the event-counting monitor.
// ----------------------------------------------------------------
module pmec_top
   import pmec_pkg::*;
#(
   parameter int WIDTH = 32, // Counter and register width.
   parameter int EVENTS = 32 // Event lines per counter.
) (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Special-register port from the core.
   input wire logic i_spr_wr,
   input wire logic i_spr_rd,
   input wire logic [1:0] i_spr_sel,
   input wire logic [WIDTH-1:0] i_spr_wdata,
   output logic [WIDTH-1:0] o_spr_rdata,
   output logic o_spr_rvalid,
   // Machine state from the core.
   input wire logic i_privilege_state_bit,
   input wire logic i_process_mark_bit,
   // Time base and event lines.
   input wire logic [63:0] i_timebase,
   input wire logic [EVENTS-1:0] i_events_one,
   input wire logic [EVENTS-1:0] i_events_two,
   // Monitor interrupt and status.
   output logic o_monitor_interrupt,
   output logic o_count_enable
);
   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta; // First stage of the release.
   logic rst_b; // Released reset used everywhere.

   // Reset asserts at once and releases after two edges.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta <= 1'b0;
         rst_b <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_b <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // Control register and decoded fields
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] monitor_control; // The control word.
   logic wr_control; // Software writes control.
   logic wr_one; // Software loads counter one.
   logic wr_two; // Software loads counter two.
   logic [WIDTH-1:0] count_one; // Counter one value.
   logic [WIDTH-1:0] count_two; // Counter two value.
   logic monitor_irq_enable; // Global interrupt enable.
   logic freeze_on_irq; // Freeze when interrupting.
   logic [1:0] timebase_bit_select; // Time-base bit choice.
   logic timebase_edge_irq_enable; // Edge interrupt enable.
   logic counter_one_negative_irq_enable; // Counter one enable.
   logic counter_two_negative_irq_enable; // Counter two enable.
   logic counter_two_trigger_hold; // Hold counter two.
   logic [6:0] counter_one_event_select; // Event code, one.
   logic [5:0] counter_two_event_select; // Event code, two.

   assign wr_control = i_spr_wr && i_spr_sel == SEL_CONTROL;
   assign wr_one = i_spr_wr && i_spr_sel == SEL_COUNT_ONE;
   assign wr_two = i_spr_wr && i_spr_sel == SEL_COUNT_TWO;

   assign monitor_irq_enable = monitor_control[IRQ_ENABLE];
   assign freeze_on_irq = monitor_control[FREEZE_ON_IRQ];
   assign timebase_bit_select = monitor_control[TB_SEL_HI:TB_SEL_LO]; // R1
   assign timebase_edge_irq_enable = monitor_control[TB_EDGE_EN];
   assign counter_one_negative_irq_enable = monitor_control[ONE_NEG_EN];
   assign counter_two_negative_irq_enable = monitor_control[TWO_NEG_EN];
   assign counter_two_trigger_hold = monitor_control[TWO_HOLD];
   assign counter_one_event_select = monitor_control[SEL_ONE_HI:SEL_ONE_LO]; // R8
   assign counter_two_event_select = monitor_control[SEL_TWO_HI:SEL_TWO_LO]; // R9

   // ----------------------------------------------------------------
   // Interrupt decision
   // ----------------------------------------------------------------
   logic tb_rise; // Chosen time-base bit rose.
   logic one_negative; // Counter one sign bit.
   logic two_negative; // Counter two sign bit.
   logic irq_now; // Interrupt is signalled this cycle.

   pmec_tb_edge u_tb_edge (
      .i_clk(i_clk_sys),
      .i_rst_b(rst_b),
      .i_timebase(i_timebase),
      .i_select(timebase_bit_select),
      .o_rise(tb_rise)
   );

   assign one_negative = count_one[SIGN_BIT]; // R15
   assign two_negative = count_two[SIGN_BIT]; // R15

   // The global enable gates every source, so once it is cleared the
   // sign bits may stay set without re-firing until software asks.
   assign irq_now = monitor_irq_enable // R20
      && ((counter_one_negative_irq_enable && one_negative) // R5
      || (counter_two_negative_irq_enable && two_negative) // R6
      || (timebase_edge_irq_enable && tb_rise)); // R2

   // ----------------------------------------------------------------
   // Control register update
   // ----------------------------------------------------------------
   // Software writes win over the hardware clear of the enable, so a
   // re-enable issued in the same cycle is not lost. Hardware touches
   // only the global enable; the edge enable is software-only.
   always_ff @(posedge i_clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         monitor_control <= CONTROL_RESET;
      end else if (wr_control) begin
         monitor_control <= i_spr_wdata; // R3 R4
      end else if (irq_now) begin
         monitor_control[IRQ_ENABLE] <= 1'b0; // R16 R20
      end
   end

   // ----------------------------------------------------------------
   // Counting gate
   // ----------------------------------------------------------------
   logic state_ok; // Current state is one that counts.

   // Each per-state freeze bit vetoes one state and the freeze-always bit vetoes
   // all; combinations give the eight conditions, and all clear counts everywhere.
   always_comb begin
      state_ok = 1'b1; // R12
      if (monitor_control[FREEZE_ALWAYS]) begin
         state_ok = 1'b0; // R13
      end
      if (monitor_control[FREEZE_SUPER] && !i_privilege_state_bit) begin
         state_ok = 1'b0; // R18 R11
      end
      if (monitor_control[FREEZE_USER] && i_privilege_state_bit) begin
         state_ok = 1'b0; // R18 R11
      end
      if (monitor_control[FREEZE_MARKED] && i_process_mark_bit) begin
         state_ok = 1'b0; // R18 R10
      end
      if (monitor_control[FREEZE_UNMARKED] && !i_process_mark_bit) begin
         state_ok = 1'b0; // R18 R10
      end
   end

   // ----------------------------------------------------------------
   // Freeze and trigger flags
   // ----------------------------------------------------------------
   logic irq_frozen; // An interrupt froze the counters.
   logic two_triggered; // Counter two has been released.

   // Both flags rearm on a control write; a setting event in the same
   // cycle wins so it is not lost.
   always_ff @(posedge i_clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_frozen <= 1'b0;
      end else if (irq_now && freeze_on_irq) begin
         irq_frozen <= 1'b1; // R17
      end else if (wr_control) begin
         irq_frozen <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         two_triggered <= 1'b0;
      end else if (one_negative || irq_now) begin
         two_triggered <= 1'b1; // R7
      end else if (wr_control) begin
         two_triggered <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Event selection and counters
   // ----------------------------------------------------------------
   logic event_one; // Selected event for counter one.
   logic event_two; // Selected event for counter two.
   logic inc_one; // Counter one counts this cycle.
   logic inc_two; // Counter two counts this cycle.
   logic two_irq_frozen; // Interrupt freeze applies to two.

   // Upper selector bits are reserved: a code using them selects no
   // event rather than aliasing onto a defined one.
   always_comb begin
      event_one = 1'b0;
      event_two = 1'b0;
      if (counter_one_event_select[6:EVENT_CODE_BITS] == 2'h0) begin
         event_one = i_events_one[counter_one_event_select[4:0]]; // R8
      end
      if (counter_two_event_select[5:EVENT_CODE_BITS] == 1'b0) begin
         event_two = i_events_two[counter_two_event_select[4:0]]; // R9
      end
   end

   // Counter two ignores the interrupt freeze while it is held for a
   // trigger, and also while its own negative interrupt is enabled.
   assign two_irq_frozen = irq_frozen && !counter_two_trigger_hold // R17
      && !counter_two_negative_irq_enable; // R6
   assign inc_one = state_ok && !irq_frozen && event_one; // R10 R17
   assign inc_two = state_ok && !two_irq_frozen && event_two // R10
      && (!counter_two_trigger_hold || two_triggered); // R7

   pmec_counter #(.WIDTH(WIDTH)) u_count_one (
      .i_clk(i_clk_sys),
      .i_rst_b(rst_b),
      .i_load(wr_one),
      .i_load_value(i_spr_wdata),
      .i_inc(inc_one),
      .o_value(count_one)
   );

   pmec_counter #(.WIDTH(WIDTH)) u_count_two (
      .i_clk(i_clk_sys),
      .i_rst_b(rst_b),
      .i_load(wr_two),
      .i_load_value(i_spr_wdata),
      .i_inc(inc_two),
      .o_value(count_two)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Reads return the value before any same-cycle write; an unused
   // select code reads zero.
   always_ff @(posedge i_clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         o_spr_rdata <= '0;
         o_spr_rvalid <= 1'b0;
      end else begin
         o_spr_rvalid <= i_spr_rd;
         case (i_spr_sel)
            SEL_CONTROL: o_spr_rdata <= i_spr_rd ? monitor_control : '0; // R4
            SEL_COUNT_ONE: o_spr_rdata <= i_spr_rd ? count_one : '0;
            SEL_COUNT_TWO: o_spr_rdata <= i_spr_rd ? count_two : '0;
            default: o_spr_rdata <= '0;
         endcase
      end
   end

   // The interrupt is a one-cycle pulse; the core latches it.
   always_ff @(posedge i_clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         o_monitor_interrupt <= 1'b0;
         o_count_enable <= 1'b0;
      end else begin
         o_monitor_interrupt <= irq_now; // R2 R5 R20
         o_count_enable <= state_ok; // R10
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // An enabled time-base edge while interrupts are allowed.
   sequence s_edge_armed;
      monitor_irq_enable && timebase_edge_irq_enable && tb_rise;
   endsequence

   // The pulse is out and the global enable has dropped with it.
   sequence s_irq_out;
      o_monitor_interrupt && !monitor_irq_enable;
   endsequence

   AST_EDGE_IRQ: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R2
      s_edge_armed and !wr_control |=> s_irq_out)
      else $error("Enabled time-base edge gave no interrupt.");
   AST_NO_IRQ_OFF: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R20
      !monitor_irq_enable |=> !o_monitor_interrupt)
      else $error("Interrupt raised while disabled.");
   AST_ONE_NEG: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R5
      monitor_irq_enable && counter_one_negative_irq_enable
      && count_one[SIGN_BIT] |=> o_monitor_interrupt)
      else $error("Counter one negative gave no interrupt.");
   AST_EN_CLEARS: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R16
      irq_now && !wr_control |=> !monitor_irq_enable ##1 !o_monitor_interrupt
      || monitor_irq_enable)
      else $error("Global enable not cleared by interrupt.");
   AST_EDGE_EN_SW: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R3
      !wr_control |=> $stable(timebase_edge_irq_enable))
      else $error("Edge enable changed without a write.");
   AST_DIS_ALL: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R13
      monitor_control[FREEZE_ALWAYS] && !i_spr_wr
      |=> $stable(count_one) && $stable(count_two))
      else $error("Counting while disabled.");
   AST_FREE_RUN: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R12
      monitor_control[FREEZE_ALWAYS:FREEZE_UNMARKED] == 5'h00
      |=> o_count_enable)
      else $error("Counting gated with no freeze bit set.");
   AST_HOLD_TWO: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R7
      counter_two_trigger_hold && !two_triggered && !wr_two
      |=> $stable(count_two))
      else $error("Counter two moved while held.");
   AST_IRQ_FREEZE: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R17
      irq_frozen && !wr_one |=> $stable(count_one))
      else $error("Counter one moved while frozen.");
   AST_SUPER_FREEZE: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R18
      monitor_control[FREEZE_SUPER] && !i_privilege_state_bit
      |-> !inc_one && !inc_two)
      else $error("Counting in supervisor while frozen there.");

   // Counter two: its own interrupt, its freeze and its trigger; then the state gate for both.
   AST_TWO_NEG: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R6
      monitor_irq_enable && counter_two_negative_irq_enable
      && two_negative |=> o_monitor_interrupt)
      else $error("Counter two negative gave no interrupt.");
   AST_TWO_IRQ_FREEZE: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R17
      irq_frozen && !counter_two_trigger_hold && !counter_two_negative_irq_enable
      && !wr_two |=> $stable(count_two))
      else $error("Counter two moved while frozen.");
   AST_TRIGGER_SET: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R7
      one_negative |=> two_triggered)
      else $error("Counter one sign bit did not release counter two.");
   AST_GATE_SHUT: assert property (@(posedge i_clk_sys) disable iff (!rst_b) // R10
      !state_ok && !i_spr_wr
      |=> $stable(count_one) && $stable(count_two))
      else $error("Counting outside the configured state.");
endmodule // pmec_top
`default_nettype wire

// File: hdl/pmec_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Shared constants for the event-counting monitor.
// ----------------------------------------------------------------
package pmec_pkg;
   // Register select codes on the special-register port.
   localparam logic [1:0] SEL_CONTROL = 2'h0;
   localparam logic [1:0] SEL_COUNT_ONE = 2'h1;
   localparam logic [1:0] SEL_COUNT_TWO = 2'h2;
   // Reset values: everything clears at startup.
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   // Control fields; index = 31 - printed bit number.
   localparam int FREEZE_ALWAYS = 31;
   localparam int FREEZE_SUPER = 30;
   localparam int FREEZE_USER = 29;
   localparam int FREEZE_MARKED = 28;
   localparam int FREEZE_UNMARKED = 27;
   localparam int IRQ_ENABLE = 26;
   localparam int FREEZE_ON_IRQ = 25;
   localparam int TB_SEL_HI = 24;
   localparam int TB_SEL_LO = 23;
   localparam int TB_EDGE_EN = 22;
   localparam int THRESH_HI = 21;
   localparam int THRESH_LO = 16;
   localparam int ONE_NEG_EN = 15;
   localparam int TWO_NEG_EN = 14;
   localparam int TWO_HOLD = 13;
   localparam int SEL_ONE_HI = 12;
   localparam int SEL_ONE_LO = 6;
   localparam int SEL_TWO_HI = 5;
   localparam int SEL_TWO_LO = 0;
   // Only the low five selector bits name an event.
   localparam int EVENT_CODE_BITS = 5;
   // Counter sign bit (printed bit 0).
   localparam int SIGN_BIT = 31;
   // Time-base bits as printed, big-endian numbering.
   localparam int TB_PICK_0 = 63;
   localparam int TB_PICK_1 = 55;
   localparam int TB_PICK_2 = 51;
   localparam int TB_PICK_3 = 47;
   localparam int TB_MSB = 63;
endpackage : pmec_pkg
`default_nettype wire

// File: hdl/pmec_counter.sv
`default_nettype none
// ----------------------------------------------------------------
// One 32-bit event counter with software load.
// ----------------------------------------------------------------
module pmec_counter
   import pmec_pkg::*;
#(
   parameter int WIDTH = 32
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Software load.
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_load_value,
   // Count one event this cycle.
   input wire logic i_inc,
   // Current count.
   output logic [WIDTH-1:0] o_value
);
   // Load beats counting, so software always sees its own value.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_value <= WIDTH'(COUNT_RESET); // R14
      end else if (i_load) begin
         o_value <= i_load_value; // R14
      end else if (i_inc) begin
         o_value <= o_value + WIDTH'(1);
      end
   end

   AST_LOAD_TAKES: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R14
      i_load |=> o_value == $past(i_load_value))
      else $error("Counter load value not taken.");
   AST_HOLD_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_load && !i_inc |=> $stable(o_value))
      else $error("Counter moved without cause.");
endmodule // pmec_counter
`default_nettype wire

// File: hdl/pmec_tb_edge.sv
`default_nettype none
// ----------------------------------------------------------------
// Picks one time-base bit and flags its rising edge.
// ----------------------------------------------------------------
module pmec_tb_edge
   import pmec_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Time base and bit choice.
   input wire logic [63:0] i_timebase,
   input wire logic [1:0] i_select,
   // Rising edge of the chosen bit.
   output logic o_rise
);
   logic picked; // Chosen bit this cycle.
   logic picked_prev; // Chosen bit one cycle ago.

   // Printed numbering is big-endian, hence TB_MSB minus the bit.
   always_comb begin
      case (i_select)
         2'h0: picked = i_timebase[TB_MSB - TB_PICK_0]; // R1
         2'h1: picked = i_timebase[TB_MSB - TB_PICK_1]; // R1
         2'h2: picked = i_timebase[TB_MSB - TB_PICK_2]; // R1
         default: picked = i_timebase[TB_MSB - TB_PICK_3]; // R1
      endcase
   end

   // A change of selection can fake one edge; software sets the
   // select before enabling the edge interrupt.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         picked_prev <= 1'b0;
      end else begin
         picked_prev <= picked; // R19
      end
   end

   assign o_rise = picked & ~picked_prev; // R19

   AST_TB_PICK47: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R1
      i_select == 2'h3 && $rose(i_timebase[16]) && $stable(i_select)
      |-> o_rise)
      else $error("Bit 47 edge missed.");
endmodule // pmec_tb_edge
`default_nettype wire

// File: tb/pmec_core_model.sv
`default_nettype none
// ----------------------------------------------------------------
// Core-side model: event pulses and the time base.
// ----------------------------------------------------------------
module pmec_core_model (
   // Requests from the bench.
   input wire logic [1:0] i_fire,
   input wire logic [4:0] i_code_one,
   input wire logic [4:0] i_code_two,
   input wire logic [63:0] i_tb_value,
   // Lines into the monitor.
   output logic [31:0] o_events_one,
   output logic [31:0] o_events_two,
   output logic [63:0] o_timebase
);
   timeunit 1ns;
   timeprecision 1ns;
   // One line pulses per event; idle lines stay low so no stray count lands.
   assign o_events_one = i_fire[0] ? (32'h1 << i_code_one) : 32'h0;
   assign o_events_two = i_fire[1] ? (32'h1 << i_code_two) : 32'h0;
   // The time base follows the bench so each edge is placed on purpose.
   assign o_timebase = i_tb_value;
endmodule // pmec_core_model
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb
   import pmec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, wr, rd, rvalid, priv, mark, irq, cen;
   logic [1:0] sel, fire;
   logic [31:0] wdata, rdata, ev1, ev2;
   logic [63:0] tb_val, tbase;
   int miscompares, checks, irq_count, cycles;
   int picks[4] = '{TB_PICK_0, TB_PICK_1, TB_PICK_2, TB_PICK_3};
   pmec_core_model core (.i_fire(fire), .i_code_one(5'h05), .i_code_two(5'h03),
      .i_tb_value(tb_val), .o_events_one(ev1), .o_events_two(ev2), .o_timebase(tbase));
   pmec_top dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_spr_wr(wr), .i_spr_rd(rd),
      .i_spr_sel(sel), .i_spr_wdata(wdata), .o_spr_rdata(rdata), .o_spr_rvalid(rvalid),
      .i_privilege_state_bit(priv), .i_process_mark_bit(mark), .i_timebase(tbase),
      .i_events_one(ev1), .i_events_two(ev2), .o_monitor_interrupt(irq),
      .o_count_enable(cen));
   // ----------------------------------------------------------------
   // Clock, interrupt tally and hang guard.
   // ----------------------------------------------------------------
   always #50 clk = ~clk;
   // The pulse lasts one cycle, so one falling edge sees it exactly once.
   always @(negedge clk) begin
      if (irq === 1'b1) begin
         irq_count++;
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   // ----------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobes drop one cycle before the next access, so none is set twice at once.
   task automatic wr_reg(input logic [1:0] s, input logic [31:0] d);
      sel = s;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rd_chk(input logic [1:0] s, input logic [31:0] exp);
      sel = s;
      rd = 1'b1;
      @(negedge clk);
      check({31'h0, rvalid}, 32'h1);
      check(rdata, exp);
      rd = 1'b0;
      @(negedge clk);
   endtask
   task automatic pulse(input logic [1:0] which);
      fire = which;
      @(negedge clk);
      fire = 2'h0;
      @(negedge clk);
   endtask
   // Both selectors point at the lines the model pulses.
   function automatic logic [31:0] sels();
      logic [31:0] c;
      c = 32'h0;
      c[SEL_ONE_HI:SEL_ONE_LO] = 7'h05;
      c[SEL_TWO_HI:SEL_TWO_LO] = 6'h03;
      return c;
   endfunction
   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd_chk(SEL_CONTROL, CONTROL_RESET);
      rd_chk(SEL_COUNT_ONE, COUNT_RESET);
      rd_chk(SEL_COUNT_TWO, COUNT_RESET);
      rd_chk(2'h3, 32'h0);
   endtask
   task automatic t_fields();
      logic [31:0] c;
      for (int p = 0; p < 2; p++) begin
         c = 32'h0;
         c[THRESH_HI:THRESH_LO] = p ? 6'h15 : 6'h3f;
         c[SEL_ONE_HI:SEL_ONE_LO] = p ? 7'h2a : 7'h7f;
         c[SEL_TWO_HI:SEL_TWO_LO] = p ? 6'h2a : 6'h3f;
         wr_reg(SEL_CONTROL, c);
         rd_chk(SEL_CONTROL, c);
      end
   endtask
   // Every freeze pattern against all four core states.
   task automatic t_gate();
      logic [31:0] c;
      logic [4:0] f;
      logic en;
      for (int k = 0; k < 128; k++) begin
         f = k[4:0];
         priv = k[5];
         mark = k[6];
         c = sels();
         c[FREEZE_ALWAYS:FREEZE_UNMARKED] = f;
         en = !(f[4] | (f[3] & !priv) | (f[2] & priv) | (f[1] & mark) | (f[0] & !mark));
         wr_reg(SEL_CONTROL, c);
         wr_reg(SEL_COUNT_ONE, 32'h0);
         wr_reg(SEL_COUNT_TWO, 32'h0);
         pulse(2'h3);
         rd_chk(SEL_COUNT_ONE, {31'h0, en});
         rd_chk(SEL_COUNT_TWO, {31'h0, en});
         check({31'h0, cen}, {31'h0, en});
      end
   endtask
   task automatic t_timebase();
      logic [31:0] c;
      int n;
      for (int s = 0; s < 6; s++) begin
         tb_val = 64'h0;
         c = 32'h0;
         c[IRQ_ENABLE] = (s != 5);
         c[TB_EDGE_EN] = (s != 4);
         c[TB_SEL_HI:TB_SEL_LO] = s[1:0];
         wr_reg(SEL_CONTROL, c);
         n = irq_count;
         tb_val[63 - picks[(s + 1) % 4]] = 1'b1;
         repeat (4) @(negedge clk);
         check(irq_count, n);
         tb_val[63 - picks[s % 4]] = 1'b1;
         repeat (4) @(negedge clk);
         check(irq_count, n + (s < 4));
         // With the edge enable off nothing fires, so the global enable stays set.
         c[IRQ_ENABLE] = (s == 4);
         rd_chk(SEL_CONTROL, c);
      end
   endtask
   task automatic t_negative();
      logic [31:0] c;
      int n;
      c = sels();
      c[IRQ_ENABLE] = 1'b1;
      wr_reg(SEL_COUNT_ONE, 32'h7fff_ffff);
      wr_reg(SEL_CONTROL, c);
      n = irq_count;
      pulse(2'h1);
      repeat (3) @(negedge clk);
      check(irq_count, n);
      c[ONE_NEG_EN] = 1'b1;
      c[TWO_NEG_EN] = 1'b1;
      c[FREEZE_ON_IRQ] = 1'b1;
      wr_reg(SEL_COUNT_ONE, 32'h7fff_ffff);
      wr_reg(SEL_COUNT_TWO, 32'h0);
      wr_reg(SEL_CONTROL, c);
      pulse(2'h3);
      repeat (3) @(negedge clk);
      check(irq_count, n + 1);
      pulse(2'h3);
      rd_chk(SEL_COUNT_ONE, 32'h8000_0000);
      rd_chk(SEL_COUNT_TWO, 32'h2);
      // Counter one is cleared first: its sign bit alone would release the hold.
      c = sels();
      c[TWO_HOLD] = 1'b1;
      wr_reg(SEL_COUNT_ONE, 32'h0);
      wr_reg(SEL_COUNT_TWO, 32'h0);
      wr_reg(SEL_CONTROL, c);
      pulse(2'h2);
      rd_chk(SEL_COUNT_TWO, 32'h0);
      wr_reg(SEL_COUNT_ONE, 32'h8000_0000);
      pulse(2'h2);
      rd_chk(SEL_COUNT_TWO, 32'h1);
   endtask
   task automatic final_report();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      {clk, rst_b, wr, rd, priv, mark} = 6'h0;
      {sel, fire, wdata, tb_val} = '0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      t_reset();
      t_fields();
      t_gate();
      priv = 1'b0;
      mark = 1'b0;
      t_timebase();
      t_negative();
      final_report();
   end
endmodule // tb
`default_nettype wire
